/* File: rtl/dtwp_timer_block.sv */
// ----------------------------------------------------------------------------
// Two timers, watchdog and pulse counter with a register port
// ----------------------------------------------------------------------------
//
// Our own choice: the plain strobed port.
module dtwp_timer_block #(
  parameter int TW  = 16,
  parameter int PW  = 10
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             timer_irq,
  output logic             first_timer_zero_out,
  output logic             second_timer_zero_out,
  output logic             pulse_pin_out,
  output logic             watchdog_carry_out
);
  import dtwp_pkg::*;

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic [TW-1:0] first_timer_count_q;
  logic [TW-1:0] second_timer_count_q;
  logic [TW-1:0] first_reload_q;
  logic [TW-1:0] second_reload_q;
  logic [7:0]    first_presc_q;
  logic [7:0]    second_presc_q;
  logic [11:0]   wd_presc_q;
  logic          first_timer_halt_q;
  logic          second_timer_halt_q;
  logic          wd_halt_q;
  logic [15:0]   wd_cnt_q;
  logic [PW-1:0] pw_cnt_q;
  logic [PW-1:0] pulse_width_setting_q;
  logic [11:0]   pulse_prescale_value_q;
  logic [3:0]    irq_flag_q;
  logic [3:0]    irq_en_q;
  logic [15:0]   watchdog_warn_threshold_q;
  logic [2:0]    pin_routing_q;
  logic [31:0]   rdata_q;
  logic [3:0]    wd_rst_cnt_q;

  logic wr_counts;
  logic wr_ctrl;
  logic wr_wd;
  logic wr_pw;
  logic wr_irq;
  logic wr_route;
  logic wr_reload;
  logic t1_tick;
  logic t2_tick;
  logic wd_tick;
  logic pw_tick;
  logic t1_zero;
  logic t2_zero;
  logic wd_clear;
  logic wd_carry;
  logic wd_warn;
  logic pw_wrap;
  logic pw_level;
  logic [3:0] irq_event;

  // Strobes are qualified by the clock enable here, so a frozen block ignores the bus.
  assign wr_counts = clk_en && wr && (addr == TIMER_COUNTS_ADDR);
  assign wr_ctrl   = clk_en && wr && (addr == TIMER_CTRL_ONE_ADDR);
  assign wr_wd     = clk_en && wr && (addr == WATCHDOG_CNT_ADDR);
  assign wr_pw     = clk_en && wr && (addr == PULSE_CFG_ADDR);
  assign wr_irq    = clk_en && wr && (addr == IRQ_STAT_CTRL_ADDR);
  assign wr_route  = clk_en && wr && (addr == PIN_ROUTING_ADDR);
  assign wr_reload = clk_en && wr && (addr == TIMER_RELOAD_ADDR);

  // --------------------------------------------------------------------------
  // Prescalers
  // --------------------------------------------------------------------------
  // The pulse prescaler has no halt bit and runs whenever the clock enable is high.
  dtwp_prescaler #(.W(8)) u_presc_t1 (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .run    (!first_timer_halt_q),
    .div    (first_presc_q),
    .tick   (t1_tick)
  );

  dtwp_prescaler #(.W(8)) u_presc_t2 (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .run    (!second_timer_halt_q),
    .div    (second_presc_q),
    .tick   (t2_tick)
  );

  dtwp_prescaler #(.W(12)) u_presc_wd (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .run    (!wd_halt_q),
    .div    (wd_presc_q),
    .tick   (wd_tick)
  );

  dtwp_prescaler #(.W(12)) u_presc_pw (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .run    (1'b1),
    .div    (pulse_prescale_value_q),
    .tick   (pw_tick)
  );

  // --------------------------------------------------------------------------
  // General-purpose timers
  // --------------------------------------------------------------------------
  assign t1_zero = (first_timer_count_q == '0);
  assign t2_zero = (second_timer_count_q == '0);

  // The flag rises on the step that leaves zero, so a zero preload interrupts on every step.
  // One write loads both timers; software that retimes one must write the other back too.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_timer_count_q <= TIMER_CNT_RST;
    end else if (wr_counts) begin
      first_timer_count_q <= wdata[TW-1:0];
    end else if (t1_tick) begin
      if (t1_zero) begin
        first_timer_count_q <= first_reload_q;
      end else begin
        first_timer_count_q <= first_timer_count_q - TW'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      second_timer_count_q <= TIMER_CNT_RST;
    end else if (wr_counts) begin
      second_timer_count_q <= wdata[16 +: TW];
    end else if (t2_tick) begin
      if (t2_zero) begin
        second_timer_count_q <= second_reload_q;
      end else begin
        second_timer_count_q <= second_timer_count_q - TW'(1);
      end
    end
  end

  // A new preload takes effect only at the next reload, never cutting short the running period.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_reload_q  <= TIMER_RELOAD_RST;
      second_reload_q <= TIMER_RELOAD_RST;
    end else if (wr_reload) begin
      first_reload_q  <= wdata[TW-1:0];
      second_reload_q <= wdata[16 +: TW];
    end
  end

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  // Halting gates the prescaler as well, so a restarted timer resumes mid-period.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_presc_q       <= T1_PRESC_RST;
      second_presc_q      <= T2_PRESC_RST;
      wd_presc_q          <= WD_PRESC_RST;
      first_timer_halt_q  <= 1'b0;
      second_timer_halt_q <= 1'b0;
      wd_halt_q           <= 1'b0;
    end else if (wr_ctrl) begin
      first_presc_q       <= wdata[T1_PRESC_LSB +: 8];
      second_presc_q      <= wdata[T2_PRESC_LSB +: 8];
      wd_presc_q          <= wdata[WD_PRESC_LSB +: 12];
      first_timer_halt_q  <= wdata[T1_HALT_BIT];
      second_timer_halt_q <= wdata[T2_HALT_BIT];
      wd_halt_q           <= wdata[WD_HALT_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------------------
  // The clear bit is never stored, so it always reads back as zero.
  assign wd_clear = wr_ctrl && wdata[WD_CLEAR_BIT];
  // A restart landing on the elapsing step wins, so software that restarts in time never sees a reset.
  assign wd_carry = wd_tick && (wd_cnt_q == 16'hffff) && !wd_clear && !wr_wd;
  // The warning compares with the value being stepped into, so it fires as the threshold is reached.
  assign wd_warn  = wd_tick && ((wd_cnt_q + 16'h0001) == watchdog_warn_threshold_q);

  // A clear and a count write cannot share a cycle, since they use different addresses.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_q <= WD_CNT_RST;
    end else if (wd_clear) begin
      wd_cnt_q <= '0;
    end else if (wr_wd) begin
      wd_cnt_q <= wdata[15:0];
    end else if (wd_tick) begin
      wd_cnt_q <= wd_cnt_q + 16'h0001;
    end
  end

  // Global reset is stretched so the rest of the chip sees a clean pulse.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wd_rst_cnt_q <= '0;
    end else if (clk_en) begin
      if (wd_carry) begin
        wd_rst_cnt_q <= 4'(WD_RESET_CYCLES);
      end else if (wd_rst_cnt_q != '0) begin
        wd_rst_cnt_q <= wd_rst_cnt_q - 4'h1;
      end
    end
  end

  // The reset request leaves a flip-flop so the rest of the chip never sees a decode glitch.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_carry_out <= 1'b0;
    end else if (clk_en) begin
      watchdog_carry_out <= wd_carry || (wd_rst_cnt_q > 4'h1);
    end
  end

  // --------------------------------------------------------------------------
  // Pulse counter
  // --------------------------------------------------------------------------
  assign pw_wrap = pw_tick && (pw_cnt_q == {PW{1'b1}});

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_width_setting_q  <= PW_WIDTH_RST;
      pulse_prescale_value_q <= PW_PRESC_RST;
    end else if (wr_pw) begin
      pulse_width_setting_q  <= wdata[PW_WIDTH_LSB +: PW];
      pulse_prescale_value_q <= wdata[PW_PRESC_LSB +: 12];
    end
  end

  // A configuration write also loads the count from its low bits, which is how a handler rearms a plain counter.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pw_cnt_q <= PW_CNT_RST;
    end else if (wr_pw) begin
      pw_cnt_q <= wdata[PW-1:0];
    end else if (pw_tick) begin
      pw_cnt_q <= pw_cnt_q + PW'(1);
    end
  end

  // Level of the pulse before routing; it is low while the count is below the width.
  assign pw_level = (pw_cnt_q >= pulse_width_setting_q);

  // --------------------------------------------------------------------------
  // Interrupt status and enables
  // --------------------------------------------------------------------------
  assign irq_event = {pw_wrap, wd_warn, t2_tick && t2_zero, t1_tick && t1_zero};

  // Hardware set wins over a software zero written in the same cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_q <= '0;
    end else if (clk_en) begin
      if (wr_irq) begin
        irq_flag_q <= (irq_flag_q & wdata[3:0]) | irq_event;
      end else begin
        irq_flag_q <= irq_flag_q | irq_event;
      end
    end
  end

  // Enables share the register with the flags, so every flag write rewrites them too.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q                  <= '0;
      watchdog_warn_threshold_q <= WD_LEV_RST;
    end else if (wr_irq) begin
      irq_en_q                  <= wdata[IRQ_EN_LSB +: 4];
      watchdog_warn_threshold_q <= wdata[WD_LEV_LSB +: 16];
    end
  end

  // Flags record events regardless; only enabled ones reach the processor.
  assign timer_irq = |(irq_flag_q & irq_en_q);

  // --------------------------------------------------------------------------
  // Pin routing
  // --------------------------------------------------------------------------
  // Pins follow the counts one cycle late because they leave through a register.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_routing_q <= '0;
    end else if (wr_route) begin
      pin_routing_q <= wdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_timer_zero_out  <= 1'b0;
      second_timer_zero_out <= 1'b0;
      pulse_pin_out         <= 1'b0;
    end else if (clk_en) begin
      first_timer_zero_out  <= pin_routing_q[ROUTE_PIN0_BIT] && t1_zero;
      second_timer_zero_out <= pin_routing_q[ROUTE_PIN1_BIT] && t2_zero;
      pulse_pin_out         <= pin_routing_q[ROUTE_PIN2_BIT] && pw_level;
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  // Read data stand for one enabled cycle only and return to zero, so a stale word never looks fresh.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (clk_en) begin
      if (rd) begin
        case (addr)
          TIMER_COUNTS_ADDR:   rdata_q <= {second_timer_count_q, first_timer_count_q};
          TIMER_CTRL_ONE_ADDR: rdata_q <= {1'b0, wd_halt_q, second_timer_halt_q, first_timer_halt_q,
                                           wd_presc_q, second_presc_q, first_presc_q};
          WATCHDOG_CNT_ADDR:   rdata_q <= {16'h0000, wd_cnt_q};
          PULSE_CFG_ADDR:      rdata_q <= {pulse_prescale_value_q, pulse_width_setting_q, pw_cnt_q};
          IRQ_STAT_CTRL_ADDR:  rdata_q <= {8'h00, watchdog_warn_threshold_q, irq_en_q, irq_flag_q};
          PIN_ROUTING_ADDR:    rdata_q <= {29'h0000_0000, pin_routing_q};
          TIMER_RELOAD_ADDR:   rdata_q <= {second_reload_q, first_reload_q};
          default:             rdata_q <= 32'h0000_0000;
        endcase
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  assign rdata = rdata_q;

endmodule // dtwp_timer_block

/* File: rtl/dtwp_pkg.sv */
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package dtwp_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [31:0] TIMER_COUNTS_ADDR   = 32'h0009_0000;
  localparam logic [31:0] TIMER_CTRL_ONE_ADDR = 32'h0009_0004;
  localparam logic [31:0] WATCHDOG_CNT_ADDR   = 32'h0009_0008;
  localparam logic [31:0] PULSE_CFG_ADDR      = 32'h0009_000c;
  localparam logic [31:0] IRQ_STAT_CTRL_ADDR  = 32'h0009_0010;
  localparam logic [31:0] PIN_ROUTING_ADDR    = 32'h0009_0024;
  localparam logic [31:0] TIMER_RELOAD_ADDR   = 32'h0009_002c;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int T1_PRESC_LSB    = 0;
  localparam int T2_PRESC_LSB    = 8;
  localparam int WD_PRESC_LSB    = 16;
  localparam int T1_HALT_BIT     = 28;
  localparam int T2_HALT_BIT     = 29;
  localparam int WD_HALT_BIT     = 30;
  localparam int WD_CLEAR_BIT    = 31;
  localparam int PW_WIDTH_LSB    = 10;
  localparam int PW_PRESC_LSB    = 20;
  localparam int IRQ_EN_LSB      = 4;
  localparam int WD_LEV_LSB      = 8;
  localparam int ROUTE_PIN0_BIT  = 0;
  localparam int ROUTE_PIN1_BIT  = 1;
  localparam int ROUTE_PIN2_BIT  = 2;
  localparam int IRQ_T1          = 0;
  localparam int IRQ_T2          = 1;
  localparam int IRQ_WD          = 2;
  localparam int IRQ_PW          = 3;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [15:0] TIMER_CNT_RST   = 16'hffff;
  localparam logic [15:0] TIMER_RELOAD_RST = 16'h0000;
  localparam logic [7:0]  T1_PRESC_RST    = 8'hbb;
  localparam logic [7:0]  T2_PRESC_RST    = 8'h00;
  localparam logic [11:0] WD_PRESC_RST    = 12'h0bb;
  localparam logic [15:0] WD_CNT_RST      = 16'h0000;
  localparam logic [9:0]  PW_CNT_RST      = 10'h000;
  localparam logic [9:0]  PW_WIDTH_RST    = 10'h001;
  localparam logic [11:0] PW_PRESC_RST    = 12'h000;
  localparam logic [15:0] WD_LEV_RST      = 16'h8000;

  // --------------------------------------------------------------------------
  // Global reset pulse length in system clocks
  // --------------------------------------------------------------------------
  localparam int WD_RESET_NS     = 100;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int WD_RESET_CYCLES = (WD_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : dtwp_pkg

/* File: rtl/dtwp_prescaler.sv */
// ----------------------------------------------------------------------------
// Prescaler: one-cycle tick every (div + 1) enabled clocks
// ----------------------------------------------------------------------------
module dtwp_prescaler #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         run,
  input  wire logic [W-1:0] div,
  output logic              tick
);
  import dtwp_pkg::*;

  logic [W-1:0] cnt_q;

  // A divider of zero ticks every cycle so the counter runs at full rate.
  assign tick = clk_en && run && (cnt_q >= div);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clk_en && run) begin
      if (tick) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end

endmodule // dtwp_prescaler

/* File: tb/dtwp_properties.sv */
// ----------------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------------
module dtwp_properties (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        timer_irq,
  input wire logic        first_timer_zero_out,
  input wire logic        second_timer_zero_out,
  input wire logic        pulse_pin_out,
  input wire logic        watchdog_carry_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import dtwp_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_irq_gate_off:
    assert property (wr && clk_en && addr == IRQ_STAT_CTRL_ADDR && wdata[7:4] == 4'h0 |=> !timer_irq)
    else $error("interrupt high with all enables off");
  a_irq_level_holds:
    assert property (timer_irq && !(wr && clk_en && addr == IRQ_STAT_CTRL_ADDR) |=> timer_irq)
    else $error("interrupt dropped without a status write");
  a_route_gate_off:
    assert property (wr && clk_en && addr == PIN_ROUTING_ADDR && wdata[2:0] == 3'h0
                     |-> ##2 !(first_timer_zero_out || second_timer_zero_out || pulse_pin_out))
    else $error("pin driven while not routed");
  a_carry_len_ten:
    assert property ($rose(watchdog_carry_out) |-> watchdog_carry_out [*8] ##1 watchdog_carry_out
                     ##1 watchdog_carry_out ##1 !watchdog_carry_out)
    else $error("watchdog reset pulse not ten cycles");
  a_clear_reads_zero:
    assert property (rd && clk_en && addr == TIMER_CTRL_ONE_ADDR |=> !rdata[31])
    else $error("watchdog clear bit reads back set");
  a_clear_no_carry:
    assert property (wr && clk_en && addr == TIMER_CTRL_ONE_ADDR && wdata[31] |=> (!$rose(watchdog_carry_out)) [*8])
    else $error("watchdog reset right after clear");
  a_wdload_no_carry:
    assert property (wr && clk_en && addr == WATCHDOG_CNT_ADDR && wdata[15:0] == 16'h0
                     |=> (!$rose(watchdog_carry_out)) [*8])
    else $error("watchdog reset right after restart");
  a_frozen_outputs:
    assert property (!clk_en |=> $stable({first_timer_zero_out, second_timer_zero_out, pulse_pin_out,
                                          watchdog_carry_out, timer_irq}))
    else $error("outputs moved while clock enable low");
endmodule // dtwp_properties

/* File: tb/dtwp_cpu_model.sv */
// ----------------------------------------------------------------------------
// Processor bus master
// ----------------------------------------------------------------------------
module dtwp_cpu_model (
  input wire logic        mclk,
  output logic     [31:0] addr,
  output logic     [31:0] wdata,
  output logic            wr,
  output logic            rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr  = 32'h0;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // Released lines show the inverse so a stale value is never mistaken for a live one.
  task automatic wr32(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask

  task automatic rd32(input logic [31:0] a);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    addr <= ~a;
  endtask
endmodule // dtwp_cpu_model

/* File: tb/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dtwp_pkg::*;
  localparam logic [31:0] RA [7] = '{TIMER_RELOAD_ADDR, TIMER_CTRL_ONE_ADDR, IRQ_STAT_CTRL_ADDR,
    WATCHDOG_CNT_ADDR, PIN_ROUTING_ADDR, PULSE_CFG_ADDR, 32'h0009_0014};
  localparam logic [31:0] RE [7] = '{32'h0, 32'h00bb_00bb, 32'h0080_0000, 32'h0, 32'h0, 32'h0000_0400, 32'h0};
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        pend = 1'b0;
  logic [31:0] addr, wdata, rdata, rnd;
  logic        wr, rd, timer_irq, z1, z2, pout, wcar;
  logic [63:0] note;
  logic [63:0] q [$];
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #5 mclk = ~mclk;

  dtwp_cpu_model cpu (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  dtwp_timer_block uut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_irq(timer_irq), .first_timer_zero_out(z1), .second_timer_zero_out(z2),
    .pulse_pin_out(pout), .watchdog_carry_out(wcar));

  // --------------------------------------------------------------------------
  // Scoreboard
  // --------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_note(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back({m, e & m});
    cpu.rd32(a);
  endtask

  always @(posedge mclk) begin
    if (pend) begin
      note = q.pop_front();
      check("rdata", note[31:0], rdata & note[63:32]);
    end
    pend <= rd & clk_en;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
  endfunction

  function automatic logic sig(input int w);
    return (w == 0) ? z1 : (w == 2) ? z2 : wcar;
  endfunction

  task automatic wait_lvl(input int w, input logic v, inout int n);
    for (int k = 0; k < 3000 && sig(w) !== v; k++) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // The ceiling sits well above the longest pulse run so only a real hang trips it.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    int n;
    int w;
    rnd = 32'hd34e_caab;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd_note(RA[i], RE[i], (i == 5) ? 32'hffff_fc00 : 32'hffff_ffff);
    $display("test reset values done");
    cpu.wr32(TIMER_CTRL_ONE_ADDR, 32'h7000_0000);
    cpu.wr32(TIMER_COUNTS_ADDR, 32'h0003_0005);
    repeat (20) @(posedge mclk);
    rd_note(TIMER_COUNTS_ADDR, 32'h0003_0005, 32'hffff_ffff);
    @(posedge mclk);
    clk_en <= 1'b0;
    cpu.wr32(PIN_ROUTING_ADDR, 32'h7);
    clk_en <= 1'b1;
    rd_note(PIN_ROUTING_ADDR, 32'h0, 32'hffff_ffff);
    $display("test load, halt and freeze done");
    cpu.wr32(TIMER_RELOAD_ADDR, 32'h0002_0004);
    cpu.wr32(PIN_ROUTING_ADDR, 32'h3);
    cpu.wr32(IRQ_STAT_CTRL_ADDR, 32'h0080_0010);
    for (int p = 0; p < 2; p++) begin
      cpu.wr32(TIMER_CTRL_ONE_ADDR, 32'h4000_0000 | 32'(p * 2));
      n = 0;
      wait_lvl(0, 1'b0, n);
      wait_lvl(0, 1'b1, n);
      n = 0;
      wait_lvl(0, 1'b0, n);
      wait_lvl(0, 1'b1, n);
      check("timer period", 32'(5 * (p * 2 + 1)), 32'(n));
      n = 0;
      wait_lvl(2, 1'b0, n);
      wait_lvl(2, 1'b1, n);
      n = 0;
      wait_lvl(2, 1'b0, n);
      wait_lvl(2, 1'b1, n);
      check("timer two period", 32'h3, 32'(n));
    end
    cpu.wr32(TIMER_CTRL_ONE_ADDR, 32'h7000_0000);
    @(negedge mclk);
    check("timer irq", 32'h1, {31'h0, timer_irq});
    rd_note(IRQ_STAT_CTRL_ADDR, 32'h3, 32'h3);
    cpu.wr32(IRQ_STAT_CTRL_ADDR, 32'h0080_0010);
    @(negedge mclk);
    check("irq cleared", 32'h0, {31'h0, timer_irq});
    $display("test timers done");
    cpu.wr32(IRQ_STAT_CTRL_ADDR, 32'h00ff_f840);
    cpu.wr32(WATCHDOG_CNT_ADDR, 32'h0000_fff0);
    cpu.wr32(TIMER_CTRL_ONE_ADDR, 32'h3000_0000);
    n = 0;
    wait_lvl(1, 1'b1, n);
    n = 0;
    wait_lvl(1, 1'b0, n);
    check("reset pulse", 32'(WD_RESET_CYCLES), 32'(n));
    check("warn irq", 32'h1, {31'h0, timer_irq});
    rd_note(IRQ_STAT_CTRL_ADDR, 32'h4, 32'h4);
    cpu.wr32(TIMER_CTRL_ONE_ADDR, 32'hb000_0000);
    cpu.wr32(TIMER_CTRL_ONE_ADDR, 32'h7000_0000);
    rd_note(WATCHDOG_CNT_ADDR, 32'h0, 32'hffff_fff8);
    rd_note(TIMER_CTRL_ONE_ADDR, 32'h7000_0000, 32'hffff_ffff);
    cpu.wr32(WATCHDOG_CNT_ADDR, 32'h0);
    cpu.wr32(IRQ_STAT_CTRL_ADDR, 32'h0080_0000);
    $display("test watchdog done");
    cpu.wr32(PIN_ROUTING_ADDR, 32'h4);
    cpu.wr32(IRQ_STAT_CTRL_ADDR, 32'h0080_0080);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      w = (i == 2) ? 0 : int'(rnd[9:0]);
      cpu.wr32(PULSE_CFG_ADDR, (32'(i == 1) << 20) | (32'(w) << 10));
      repeat (2) @(negedge mclk);
      n = 0;
      for (int k = 0; k < 1024 * ((i == 1) + 1); k++) begin
        @(negedge mclk);
        if (pout === 1'b1) n++;
      end
      check("pulse high count", 32'((1024 - w) * ((i == 1) + 1)), 32'(n));
    end
    check("pulse irq", 32'h1, {31'h0, timer_irq});
    rd_note(IRQ_STAT_CTRL_ADDR, 32'h8, 32'h8);
    cpu.wr32(PIN_ROUTING_ADDR, 32'h0);
    repeat (2) @(negedge mclk);
    check("unrouted pins", 32'h0, {29'h0, z2, pout, z1});
    $display("test pulse counter done");
    repeat (3) @(posedge mclk);
    close_out();
  end
endmodule // testbench

bind dtwp_timer_block dtwp_properties chk (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timer_irq(timer_irq),
  .first_timer_zero_out(first_timer_zero_out), .second_timer_zero_out(second_timer_zero_out),
  .pulse_pin_out(pulse_pin_out), .watchdog_carry_out(watchdog_carry_out));
